// ==== verilog/usdr_top.sv ====
// Serial channel status, transmit data and receive data registers.
// Assumes a classic Wishbone master and an outside serializer that
// takes a byte on TX_START and reports TX_DONE when the line is idle,
// and an outside deserializer that presents bytes with error flags.
//
// Function
// [R1] Framing fault flag, status bit 6, set on error, reset 0, cleared by writing 1.
// [R2] Parity fault flag, status bit 5, set on error, reset 0, software writable.
// [R3] Overrun fault flag, status bit 4, set on overrun, reset 0, software writable.
// [R4] Status bit 3 shows a second received byte waiting; read-only, reset 0.
// [R5] Status bit 1 shows received data available; read-only, reset 0.
// [R6] Status bit 2 shows the transmit shifter busy; read-only, reset 0.
// [R7] Status bit 0 shows transmit buffer empty; read-only, reset 1.
// [R8] Infrared mode bit, read/write, reset 0, switches channel to infrared operation.
// [R9] Transmit byte register takes the byte to send; seven-bit frames mask to 0x7f.
// [R10] Receive byte register returns the older buffered byte; resets 0.
// [R11] Error flags stay set until software clears them.
`timescale 1ns/1ps
module usdr_top
    import usdr_pkg::*;
#(
    parameter int ADR_W = 18
) (
    // Clock and reset
    input  wire logic             REF_CLK,
    input  wire logic             SRST,
    // Wishbone slave
    input  wire logic             WB_CYC_I,
    input  wire logic             WB_STB_I,
    input  wire logic             WB_WE_I,
    input  wire logic [ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]       WB_SEL_I,
    input  wire logic [31:0]      WB_DAT_I,
    output logic [31:0]           WB_DAT_O,
    output logic                  WB_ACK_O,
    // Transmit side toward the serializer
    output logic [7:0]            TX_BYTE,
    output logic                  TX_START,
    input  wire logic             TX_DONE,
    // Receive side from the deserializer
    input  wire logic             RX_VALID,
    input  wire logic [7:0]       RX_BYTE,
    input  wire logic             RX_FRAMING_ERR,
    input  wire logic             RX_PARITY_ERR,
    // Channel mode
    output logic                  INFRARED_MODE,
    output logic                  SEVEN_BIT_FRAME
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0]                 dat;
        logic                        ack;
        logic                        framing_fault_flag;
        logic                        parity_fault_flag;
        logic                        overrun_fault_flag;
        logic                        tx_shift_active;
        logic [7:0]                  tx_byte;
        logic [7:0]                  tx_shift_byte;
        logic                        tx_start;
        logic                        infrared_mode_select;
        logic                        seven_bit;
        logic [RX_BUF_DEPTH-1:0][7:0] rx_buf;
        logic [1:0]                  rx_cnt;
        logic [7:0]                  rx_last;
    } usdr_state_t;

    usdr_state_t s_q;
    usdr_state_t s_d;

    // ==========================================================
    // Bus decode
    logic [15:0] idx;
    logic        req;
    logic        hit_status;
    logic        hit_tx;
    logic        hit_rx;
    logic        hit_mode;
    logic        wr_lane0;
    logic        do_access;
    logic        rx_pop;
    logic        rx_push;
    logic [1:0]  rx_cnt_after_pop;
    logic [7:0]  wr_byte;

    // Word index from the byte address
    assign idx        = 16'(WB_ADR_I[ADR_W-1:2]);
    assign req        = WB_CYC_I && WB_STB_I && !s_q.ack;
    assign hit_status = (idx == IDX_CHANNEL_STATUS);
    assign hit_tx     = (idx == IDX_TRANSMIT_BYTE);
    assign hit_rx     = (idx == IDX_RECEIVE_BYTE);
    assign hit_mode   = (idx == IDX_CHANNEL_MODE);
    assign wr_lane0   = WB_WE_I && WB_SEL_I[0];
    assign wr_byte    = WB_DAT_I[7:0];

    // ==========================================================
    // Transmit FIFO in front of the shifter
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic       fifo_empty;

    // A full FIFO holds the bus write in wait states, never drops it
    assign do_access      = req && !(hit_tx && wr_lane0 && !fifo_in_ready);
    assign fifo_in_valid  = do_access && hit_tx && wr_lane0;
    assign fifo_in_data   = s_q.seven_bit ? (wr_byte & SEVEN_BIT_MASK) : wr_byte; // R9
    assign fifo_out_ready = !s_q.tx_shift_active && !s_q.tx_start;

    usdr_fifo #(
        .WIDTH (8),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (REF_CLK),
        .srst      (SRST),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .empty     (fifo_empty)
    );

    // ==========================================================
    // Receive buffer handshakes
    assign rx_pop  = do_access && !WB_WE_I && hit_rx && (s_q.rx_cnt != 2'd0);
    assign rx_push = RX_VALID;
    assign rx_cnt_after_pop = rx_pop ? s_q.rx_cnt - 2'd1 : s_q.rx_cnt;

    // ==========================================================
    // Next state
    always_comb begin
        s_d          = s_q;
        s_d.ack      = do_access;
        s_d.tx_start = 1'b0;

        // Read data, registered alongside ack; unmapped reads give zero
        s_d.dat = '0;
        if (do_access && !WB_WE_I) begin
            if (hit_status) begin
                s_d.dat[BIT_FRAMING_FAULT]   = s_q.framing_fault_flag;   // R1
                s_d.dat[BIT_PARITY_FAULT]    = s_q.parity_fault_flag;    // R2
                s_d.dat[BIT_OVERRUN_FAULT]   = s_q.overrun_fault_flag;   // R3
                s_d.dat[BIT_SECOND_WAITING]  = (s_q.rx_cnt == 2'd2);     // R4
                s_d.dat[BIT_TX_SHIFT_ACTIVE] = s_q.tx_shift_active;      // R6
                s_d.dat[BIT_RX_AVAILABLE]    = (s_q.rx_cnt != 2'd0);     // R5
                s_d.dat[BIT_TX_VACANT]       = fifo_empty;               // R7
            end else if (hit_tx) begin
                s_d.dat[7:0] = s_q.tx_byte;
            end else if (hit_rx) begin
                // Older byte; empty buffer shows the last byte taken
                s_d.dat[7:0] = (s_q.rx_cnt != 2'd0) ? s_q.rx_buf[0] : s_q.rx_last; // R10
            end else if (hit_mode) begin
                s_d.dat[BIT_INFRARED_MODE]   = s_q.infrared_mode_select;
                s_d.dat[BIT_SEVEN_BIT_FRAME] = s_q.seven_bit;
            end
        end

        // Software writes: one clears a fault flag, zero leaves it
        if (do_access && wr_lane0 && hit_status) begin
            if (wr_byte[BIT_FRAMING_FAULT]) begin
                s_d.framing_fault_flag = 1'b0;                           // R1
            end
            if (wr_byte[BIT_PARITY_FAULT]) begin
                s_d.parity_fault_flag = 1'b0;                            // R2
            end
            if (wr_byte[BIT_OVERRUN_FAULT]) begin
                s_d.overrun_fault_flag = 1'b0;                           // R3
            end
        end
        if (do_access && wr_lane0 && hit_mode) begin
            s_d.infrared_mode_select = wr_byte[BIT_INFRARED_MODE];       // R8
            s_d.seven_bit            = wr_byte[BIT_SEVEN_BIT_FRAME];
        end
        if (fifo_in_valid) begin
            s_d.tx_byte = fifo_in_data;                                  // R9
        end

        // Hardware sets come after the clears so a same-cycle event wins
        if (RX_VALID && RX_FRAMING_ERR) begin
            s_d.framing_fault_flag = 1'b1;                               // R11
        end
        if (RX_VALID && RX_PARITY_ERR) begin
            s_d.parity_fault_flag = 1'b1;                                // R11
        end

        // Receive buffer: pop shifts the newer byte down, push appends
        if (rx_pop) begin
            s_d.rx_last   = s_q.rx_buf[0];
            s_d.rx_buf[0] = s_q.rx_buf[1];
        end
        s_d.rx_cnt = rx_cnt_after_pop;
        if (rx_push) begin
            if (rx_cnt_after_pop == 2'(RX_BUF_DEPTH)) begin
                // Full buffer keeps its bytes; the new one is lost
                s_d.overrun_fault_flag = 1'b1;                           // R3
            end else begin
                s_d.rx_buf[rx_cnt_after_pop[0]] = RX_BYTE;               // R5
                s_d.rx_cnt = rx_cnt_after_pop + 2'd1;                    // R4
            end
        end

        // Shifter: load from FIFO when idle, free again on done
        if (s_q.tx_shift_active && TX_DONE) begin
            s_d.tx_shift_active = 1'b0;                                  // R6
        end
        if (fifo_out_valid && fifo_out_ready) begin
            s_d.tx_shift_byte   = fifo_out_data;
            s_d.tx_start        = 1'b1;
            s_d.tx_shift_active = 1'b1;                                  // R6
        end
    end

    // State register
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            s_q         <= '0;
            s_q.tx_byte <= RST_TRANSMIT_BYTE;
            s_q.rx_last <= RST_RECEIVE_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    // Every port comes straight from the state register, so no
    // decode path or FIFO flag ever reaches a pin combinationally.
    // Bus answer: data and ack launch together one edge after the
    // request is seen; the master samples both at the next edge.
    assign WB_DAT_O        = s_q.dat;
    assign WB_ACK_O        = s_q.ack;
    // Serializer handoff: the start pulse stands one cycle and the
    // byte holds steady until the next load, which cannot come
    // before TX_DONE frees the shifter.
    assign TX_BYTE         = s_q.tx_shift_byte;
    assign TX_START        = s_q.tx_start;
    // Channel mode straight to the line logic
    assign INFRARED_MODE   = s_q.infrared_mode_select;              // R8
    assign SEVEN_BIT_FRAME = s_q.seven_bit;

    // ==========================================================
    // Usage notes
    //
    // Bus timing
    // A request is taken on the first edge at which cycle and strobe
    // are high, no ack is pending and no transmit write meets a full FIFO. Ack rises after that edge and
    // falls one cycle later, since a pending ack masks the request.
    // A master that keeps strobe high across two transfers therefore
    // sees one idle cycle between acks; that costs bandwidth but keeps
    // a held request from being taken twice.
    //
    // Transmit path
    // Writes to the transmit byte go into an eight-deep FIFO. When the
    // FIFO is full the write is held in wait states, never dropped, so
    // software may stream bytes without polling the vacant flag.
    // The vacant flag reports the FIFO alone; a byte already in the
    // shifter shows only in the shift-active flag.
    // Reading the transmit byte returns the last value written, after
    // masking, not the byte currently on the line.
    // The seven-bit mask is applied at write time. Changing the frame
    // width while bytes wait in the FIFO leaves them as written.
    //
    // Receive path
    // Two bytes are held. A third byte arriving while both are held is
    // lost and raises the overrun flag; the held bytes are kept so the
    // oldest data survives.
    // A read of the receive byte pops the older byte. Reading with an
    // empty buffer shows the last byte taken and pops nothing.
    // A pop and a push may fall in one cycle; the pop is counted first
    // so a full buffer being drained does not report a false overrun.
    //
    // Fault flags
    // Each flag is sticky. Writing one clears it, writing zero leaves
    // it. When a new fault and a clear meet in one cycle the fault
    // wins, so no error can slip past between read and clear.
    //
    // Reset
    // Everything returns to zero except the vacant flag, which follows
    // the emptied FIFO. A byte in flight in the outside serializer is
    // not aborted here; the serializer must be reset alongside.
endmodule : usdr_top

// ==== verilog/usdr_pkg.sv ====
// Constants for the serial channel status and data register block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package usdr_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_CHANNEL_STATUS = 16'h4120;
    localparam logic [15:0] IDX_TRANSMIT_BYTE  = 16'h4121;
    localparam logic [15:0] IDX_RECEIVE_BYTE   = 16'h4122;
    localparam logic [15:0] IDX_CHANNEL_MODE   = 16'h4124;
    // ==========================================================
    // Status field positions
    localparam int BIT_FRAMING_FAULT   = 6;
    localparam int BIT_PARITY_FAULT    = 5;
    localparam int BIT_OVERRUN_FAULT   = 4;
    localparam int BIT_SECOND_WAITING  = 3;
    localparam int BIT_TX_SHIFT_ACTIVE = 2;
    localparam int BIT_RX_AVAILABLE    = 1;
    localparam int BIT_TX_VACANT       = 0;
    // Mode field positions
    localparam int BIT_INFRARED_MODE   = 0;
    localparam int BIT_SEVEN_BIT_FRAME = 1;
    // ==========================================================
    // Reset values and widths
    localparam logic [7:0] RST_TRANSMIT_BYTE = 8'h00;
    localparam logic [7:0] RST_RECEIVE_BYTE  = 8'h00;
    localparam logic [7:0] SEVEN_BIT_MASK    = 8'h7f;
    localparam int         TX_FIFO_DEPTH     = 8;
    localparam int         RX_BUF_DEPTH      = 2;
endpackage : usdr_pkg

// ==== verilog/usdr_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module usdr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Level
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } usdr_fifo_st_t;

    usdr_fifo_st_t s_q;
    usdr_fifo_st_t s_d;
    logic          push;
    logic          pop;

    // ==========================================================
    // Flags straight from the count, so full and empty never lie
    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign empty     = (s_q.cnt == '0);
    assign out_data  = s_q.mem[s_q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next state
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : usdr_fifo

// ==== dv/usdr_partner.sv ====
// Far-side model: serializer that shifts each started byte, deserializer fed by tasks.
// Assumes TX_DONE is a one-cycle pulse when the line falls idle.
`timescale 1ns/1ps
module usdr_partner #(
    parameter int SHIFT_CYC = 40
) (
    input  wire logic       clk,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_start,
    output logic            tx_done,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_framing_err,
    output logic            rx_parity_err
);
    logic [7:0] cap_q = 8'h00;
    int         n_cap = 0;
    int         busy  = 0;
    initial {tx_done, rx_valid, rx_byte, rx_framing_err, rx_parity_err} = '0;
    // Serializer: captures the byte, stays busy for the frame time
    always @(posedge clk) begin
        tx_done <= (busy == 1);
        if (busy > 0) busy <= busy - 1;
        if (tx_start) begin
            cap_q <= tx_byte;
            n_cap <= n_cap + 1;
            busy  <= SHIFT_CYC;
        end
    end
    // Deserializer: one valid cycle, then lines show the inverse
    task automatic send(input logic [7:0] b, input logic fe, input logic pe);
        @(posedge clk);
        {rx_valid, rx_byte, rx_framing_err, rx_parity_err} <= {1'b1, b, fe, pe};
        @(posedge clk);
        {rx_valid, rx_byte, rx_framing_err, rx_parity_err} <= {1'b0, ~b, ~fe, ~pe};
    endtask : send
endmodule : usdr_partner

// ==== dv/usdr_top_assertions.sv ====
// Checker on the ports of the register block; models receive fill and sticky faults.
// Assumes receive pops and status clears never coincide with RX_VALID.
`timescale 1ns/1ps
module usdr_chk
    import usdr_pkg::*;
#(
    parameter int ADR_W = 18
) (
    input wire logic             REF_CLK,
    input wire logic             SRST,
    input wire logic             WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [31:0]      WB_DAT_I,
    input wire logic [31:0]      WB_DAT_O,
    input wire logic             WB_ACK_O,
    input wire logic [7:0]       TX_BYTE,
    input wire logic             TX_START,
    input wire logic             RX_VALID,
    input wire logic             RX_FRAMING_ERR,
    input wire logic             RX_PARITY_ERR,
    input wire logic             INFRARED_MODE,
    input wire logic             SEVEN_BIT_FRAME
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    logic [1:0] cnt_q;
    logic       fe_q, pe_q, oe_q;
    wire  st_a = WB_ADR_I == ADR_W'({IDX_CHANNEL_STATUS, 2'b00});
    wire  st_rd = WB_ACK_O && !WB_WE_I && st_a;
    wire  st_wr = WB_ACK_O && WB_WE_I && st_a;
    wire  rx_rd = WB_ACK_O && !WB_WE_I && WB_ADR_I == ADR_W'({IDX_RECEIVE_BYTE, 2'b00});
    wire  md_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == ADR_W'({IDX_CHANNEL_MODE, 2'b00});
    // Two-deep receive fill; a third byte is an overrun and is dropped
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            {cnt_q, fe_q, pe_q, oe_q} <= '0;
        end else begin
            if (RX_VALID) begin
                if (cnt_q == 2'd2) oe_q <= 1'b1;
                else cnt_q <= cnt_q + 2'd1;
                fe_q <= fe_q | RX_FRAMING_ERR;
                pe_q <= pe_q | RX_PARITY_ERR;
            end
            if (rx_rd && cnt_q != 2'd0) cnt_q <= cnt_q - 2'd1;
            if (st_wr && WB_DAT_I[BIT_FRAMING_FAULT]) fe_q <= 1'b0;
        end
    end
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
    property p_rx_avail; st_rd |-> WB_DAT_O[1] == (cnt_q != 2'd0); endproperty
    a_rx_avail: assert property (p_rx_avail) else $error("rx available wrong");
    property p_second; st_rd |-> WB_DAT_O[3] == (cnt_q == 2'd2); endproperty
    a_second: assert property (p_second) else $error("second byte flag wrong");
    property p_frame; st_rd |-> WB_DAT_O[6] == fe_q; endproperty
    a_frame: assert property (p_frame) else $error("framing flag wrong");
    property p_parity; st_rd |-> WB_DAT_O[5] == pe_q; endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");
    property p_overrun; st_rd |-> WB_DAT_O[4] == oe_q && !WB_DAT_O[7]; endproperty
    a_overrun: assert property (p_overrun) else $error("overrun flag wrong");
    property p_irda; md_wr |=> INFRARED_MODE == $past(WB_DAT_I[0]); endproperty
    a_irda: assert property (p_irda) else $error("infrared mode not taken");
    property p_mode_rst; $fell(SRST) |-> !INFRARED_MODE && !SEVEN_BIT_FRAME; endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode not reset");
    property p_seven; TX_START && SEVEN_BIT_FRAME |-> !TX_BYTE[7]; endproperty
    a_seven: assert property (p_seven) else $error("seven-bit byte unmasked");
    c_second: cover property (st_rd && cnt_q == 2'd2);
    c_overrun: cover property (st_rd && oe_q);
    c_seven: cover property (TX_START && SEVEN_BIT_FRAME);
endmodule : usdr_chk
bind usdr_top usdr_chk #(.ADR_W(ADR_W)) u_chk (.REF_CLK(REF_CLK), .SRST(SRST),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .TX_BYTE(TX_BYTE), .TX_START(TX_START), .RX_VALID(RX_VALID),
    .RX_FRAMING_ERR(RX_FRAMING_ERR), .RX_PARITY_ERR(RX_PARITY_ERR),
    .INFRARED_MODE(INFRARED_MODE), .SEVEN_BIT_FRAME(SEVEN_BIT_FRAME));

// ==== dv/usdr_top_bench.sv ====
// Self-checking bench: Wishbone master, random bytes, far-side model.
// Assumes word-aligned register indices and data in the low byte.
`timescale 1ns/1ps
module usdr_top_bench;
    import usdr_pkg::*;
    logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
    logic [17:0] adr = '0;
    logic [31:0] dat = '0, dat_o;
    logic ack, tx_start, tx_done, rxv, rfe, rpe, irda, seven;
    logic [7:0] txb, rxb, q, b, s1;
    logic [31:0] seed = 32'h694b0908;
    int n_mismatch = 0, tests_run = 0;
    logic [7:0] sent[$];
    always #10 clk = ~clk;
    usdr_top uut (.REF_CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .TX_BYTE(txb), .TX_START(tx_start), .TX_DONE(tx_done),
        .RX_VALID(rxv), .RX_BYTE(rxb), .RX_FRAMING_ERR(rfe), .RX_PARITY_ERR(rpe),
        .INFRARED_MODE(irda), .SEVEN_BIT_FRAME(seven));
    usdr_partner pm (.clk(clk), .tx_byte(txb), .tx_start(tx_start), .tx_done(tx_done),
        .rx_valid(rxv), .rx_byte(rxb), .rx_framing_err(rfe), .rx_parity_err(rpe));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, idx, 2'b00, 24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o[7:0];
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        chk("register", e, q);
    endtask : rd
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // Watchdog well beyond two bursts of nine frames
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(IDX_CHANNEL_STATUS, 8'h01);
        rd(IDX_TRANSMIT_BYTE, RST_TRANSMIT_BYTE);
        rd(IDX_RECEIVE_BYTE, RST_RECEIVE_BYTE);
        rd(IDX_CHANNEL_MODE, 8'h00);
        wb(1'b0, 16'h4127, 8'h00);
        // Nine back-to-back bytes fill shifter and FIFO, eight-bit then seven-bit
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, IDX_CHANNEL_MODE, {6'h0, k[0], ~k[0]});
            chk("irda", {7'h0, ~k[0]}, {7'h0, irda});
            for (int j = 0; j < 9; j++) begin
                b = rnd();
                wb(1'b1, IDX_TRANSMIT_BYTE, b);
                sent.push_back(k[0] ? (b & SEVEN_BIT_MASK) : b);
            end
            rd(IDX_TRANSMIT_BYTE, k[0] ? (b & SEVEN_BIT_MASK) : b);
            rd(IDX_CHANNEL_STATUS, 8'h04);
            for (int j = 0; j < 9; j++) begin
                while (pm.n_cap != k * 9 + j + 1) @(posedge clk);
                chk("sent", sent.pop_front(), pm.cap_q);
            end
            while (pm.busy != 0) @(posedge clk);
            repeat (2) @(posedge clk);
            rd(IDX_CHANNEL_STATUS, 8'h01);
        end
        wb(1'b1, IDX_CHANNEL_MODE, 8'h00);
        // Two bytes in, popped oldest first
        s1 = rnd();
        b = rnd();
        pm.send(s1, 1'b0, 1'b0);
        pm.send(b, 1'b0, 1'b0);
        rd(IDX_CHANNEL_STATUS, 8'h0b);
        rd(IDX_RECEIVE_BYTE, s1);
        rd(IDX_CHANNEL_STATUS, 8'h03);
        rd(IDX_RECEIVE_BYTE, b);
        // Framing fault stays through a clean frame until written with one
        pm.send(rnd(), 1'b1, 1'b0);
        pm.send(rnd(), 1'b0, 1'b0);
        rd(IDX_CHANNEL_STATUS, 8'h4b);
        wb(1'b0, IDX_RECEIVE_BYTE, 8'h00);
        wb(1'b0, IDX_RECEIVE_BYTE, 8'h00);
        wb(1'b1, IDX_CHANNEL_STATUS, 8'h40);
        rd(IDX_CHANNEL_STATUS, 8'h01);
        // Parity fault, then a third byte overruns the full buffer
        s1 = rnd();
        pm.send(s1, 1'b0, 1'b1);
        pm.send(rnd(), 1'b0, 1'b0);
        pm.send(rnd(), 1'b0, 1'b0);
        rd(IDX_CHANNEL_STATUS, 8'h3b);
        rd(IDX_RECEIVE_BYTE, s1);
        final_report();
    end
endmodule : usdr_top_bench
